/* olr_checker.sv */
`timescale 1ns/1ps
module olr_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        port1_link_lost,
	input wire logic [1:0]  model_sel,
	input wire logic        ext_mode,
	input wire logic        read_req,
	input wire logic        read_ack,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic       wr  = psel && penable && pwrite && !pready;
	wire logic       rd  = pready && !pwrite;
	wire logic [2:0] pat = {pwdata[6], pwdata[3:2]};
	property p_ans; psel && $rose(penable) |=> pready ##1 !pready; endproperty
	a_ans: assert property (p_ans) else $error("access not closed after one wait state");
	property p_err; rd && paddr == 12'h200 |-> pslverr && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped read not refused");
	property p_ver; rd && paddr == 12'h124 |-> prdata[7:6] == olr_pkg::HW_VERSION; endproperty
	a_ver: assert property (p_ver) else $error("version field wrong");
	property p_link; rd && paddr == 12'h124 |-> prdata[0] == $past(port1_link_lost, 2); endproperty
	a_link: assert property (p_link) else $error("link down bit wrong");
	property p_cap; rd && paddr == 12'h128 |-> prdata[5:4] == olr_pkg::EXT_CAPABILITY; endproperty
	a_cap: assert property (p_cap) else $error("capability field wrong");
	property p_model; wr && paddr == 12'h124 |=> ##1 model_sel == $past(pwdata[5:4], 2); endproperty
	a_model: assert property (p_model) else $error("model select wrong");
	property p_ext; wr && paddr == 12'h128 |=> ##1
		ext_mode == ($past(pwdata[1:0], 2) == olr_pkg::MODE_EXTENDED); endproperty
	a_ext: assert property (p_ext) else $error("extended mode wrong");
	property p_req; wr && paddr == 12'h128 |=> ##1 read_req == ($past(pat, 2) == olr_pkg::PAT_READ_REQ)
		&& read_ack == ($past(pat, 2) == olr_pkg::PAT_READ_ACK); endproperty
	a_req: assert property (p_req) else $error("read request decode wrong");
	c_irq: cover property (irq);
	c_ack: cover property (read_ack);
	c_err: cover property (pslverr);
endmodule : olr_checker
bind olr_regs olr_checker u_chk (.*);

/* olr_pkg.sv */
// Overview of operation
// - Center side counts loop-back timeouts, 8 bits.
// - Center side counts good loop-back returns, 8 bits.
// - Writing zero to control clears both counters.
// - Status bits 7:6 give fixed hardware version.
// - Status bits 5:4 select reach model.
// - Status bit 2: loop overstay, clear on read.
// - Status bit 1: reply timeout, clear on read.
// - Status bit 0 follows port 1 link down.
// - Bits 6,3,2 decode read request or acknowledge.
// - Bits 5:4 read-only capability, reset 10.
// - Mode field 10 selects extended mode.
package olr_pkg;
	localparam logic [7:0] OFF_LB_CTRL     = 8'h44;
	localparam logic [7:0] OFF_TO_COUNT    = 8'h47;
	localparam logic [7:0] OFF_GOOD_COUNT  = 8'h48;
	localparam logic [7:0] OFF_STATUS      = 8'h49;
	localparam logic [7:0] OFF_RCMD1       = 8'h4A;
	localparam logic [7:0] OFF_IRQ_STATUS  = 8'h60;
	localparam logic [7:0] OFF_IRQ_MASK    = 8'h61;
	localparam logic [7:0] OFF_CONFIG      = 8'h62;
	// Arbitrary revision value.
	localparam logic [1:0] HW_VERSION      = 2'h2;
	localparam logic [1:0] MODEL_15KM      = 2'h0;
	localparam logic [1:0] MODEL_40KM      = 2'h1;
	localparam logic [7:0] LB_CTRL_RESET   = 8'h00;
	localparam logic [7:0] RCMD1_RESET     = 8'h22;
	localparam logic [1:0] EXT_CAPABILITY  = 2'h2;
	localparam logic [1:0] MODE_EXTENDED   = 2'h2;
	localparam logic [2:0] PAT_READ_REQ    = 3'h1;
	localparam logic [2:0] PAT_READ_ACK    = 3'h5;
	localparam int         BIT_STOP        = 3;
	localparam int         BIT_OVERSTAY    = 2;
	localparam int         BIT_REPLY_TO    = 1;
	localparam int         IRQ_TO_COUNT    = 0;
	localparam int         IRQ_GOOD_COUNT  = 1;
	localparam int         IRQ_STOP        = 2;
	localparam int         IRQ_OVERSTAY    = 3;
	localparam int         IRQ_REPLY_TO    = 4;
	localparam int         IRQ_LINK_LOST   = 5;
	localparam int         IRQ_W           = 6;
endpackage : olr_pkg

/* olr_regs.sv */
`timescale 1ns/1ps
module olr_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        lb_timeout_evt,
	input  wire logic        lb_good_evt,
	input  wire logic        far_stop_evt,
	input  wire logic        overstay_evt,
	input  wire logic        reply_wait_evt,
	input  wire logic        port1_link_lost,
	output logic             center_side,
	output logic [1:0]       model_sel,
	output logic             ext_mode,
	output logic             read_req,
	output logic             read_ack,
	output logic             irq
);
	logic [7:0]                to_cnt_q;
	logic [7:0]                to_cnt_d;
	logic [7:0]                good_cnt_q;
	logic [7:0]                good_cnt_d;
	logic [7:0]                lb_ctrl_q;
	logic [7:0]                lb_ctrl_d;
	logic [7:0]                rcmd_q;
	logic [7:0]                rcmd_d;
	logic [1:0]                model_q;
	logic [1:0]                model_d;
	logic [3:1]                flag_q;
	logic [3:1]                flag_d;
	logic [3:1]                flag_evt;
	logic                      link_q;
	logic                      link_d;
	logic                      center_q;
	logic                      center_d;
	logic [olr_pkg::IRQ_W-1:0] ist_q;
	logic [olr_pkg::IRQ_W-1:0] ist_d;
	logic [olr_pkg::IRQ_W-1:0] imask_q;
	logic [olr_pkg::IRQ_W-1:0] imask_d;
	logic [olr_pkg::IRQ_W-1:0] ev;
	logic                      pend_q;
	logic                      pend_d;
	logic [31:0]               rdata_d;
	logic                      ready_q;
	logic                      ready_d;
	logic                      err_d;
	logic                      access;
	logic                      wr;
	logic                      rd;
	logic                      hit;
	logic                      ctrl_clear;
	logic                      status_rd;
	logic [7:0]                waddr;
	logic                      ext_d;
	logic                      req_d;
	logic                      ack_d;

	function automatic logic [7:0] word_index(input logic [11:0] a);
		word_index = a[9:2];
	endfunction : word_index

	function automatic logic sel(input logic [7:0] i, input logic [7:0] off);
		sel = (i == off);
	endfunction : sel

	function automatic logic mapped(input logic [7:0] i);
		mapped = sel(i, olr_pkg::OFF_LB_CTRL) || sel(i, olr_pkg::OFF_TO_COUNT)
			|| sel(i, olr_pkg::OFF_GOOD_COUNT) || sel(i, olr_pkg::OFF_STATUS)
			|| sel(i, olr_pkg::OFF_RCMD1) || sel(i, olr_pkg::OFF_IRQ_STATUS)
			|| sel(i, olr_pkg::OFF_IRQ_MASK) || sel(i, olr_pkg::OFF_CONFIG);
	endfunction : mapped

	// Bits 6, 3 and 2 of the command byte form the read request pattern.
	function automatic logic [2:0] cmd_pattern(input logic [7:0] c);
		cmd_pattern = {c[6], c[3:2]};
	endfunction : cmd_pattern

	// The access phase lasts two cycles: the answer is registered in the first.
	assign waddr      = word_index(paddr);
	assign hit        = mapped(waddr) && (paddr[11:10] == 2'h0);
	assign access     = psel && penable && !ready_q;
	assign wr         = access && pwrite && hit;
	assign rd         = access && !pwrite && hit;
	assign ctrl_clear = wr && sel(waddr, olr_pkg::OFF_LB_CTRL) && (pwdata[7:0] == 8'h00);
	assign status_rd  = rd && sel(waddr, olr_pkg::OFF_STATUS);

	// Bus answer: ready, error and read data are all registered.
	always_comb begin
		ready_d = access;
		err_d   = access && !hit;
		rdata_d = 32'h0000_0000;
		if (rd) begin
			case (waddr)
				olr_pkg::OFF_LB_CTRL:    rdata_d[7:0] = lb_ctrl_q;
				olr_pkg::OFF_TO_COUNT:   rdata_d[7:0] = to_cnt_q;
				olr_pkg::OFF_GOOD_COUNT: rdata_d[7:0] = good_cnt_q;
				olr_pkg::OFF_STATUS:     rdata_d[7:0] = {olr_pkg::HW_VERSION, model_q,
					flag_q, link_q};
				olr_pkg::OFF_RCMD1:      rdata_d[7:0] = rcmd_q;
				olr_pkg::OFF_IRQ_STATUS: rdata_d[olr_pkg::IRQ_W-1:0] = ist_q;
				olr_pkg::OFF_IRQ_MASK:   rdata_d[olr_pkg::IRQ_W-1:0] = imask_q;
				olr_pkg::OFF_CONFIG:     rdata_d[0] = center_q;
				default:                 rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			ready_q <= ready_d;
			pslverr <= err_d;
			prdata  <= rdata_d;
		end
	end

	assign pready = ready_q;

	// Counters only run on the center side and stop at full scale; a clear wins.
	always_comb begin
		to_cnt_d   = to_cnt_q;
		good_cnt_d = good_cnt_q;
		if (center_q && lb_timeout_evt && to_cnt_q != 8'hFF) begin
			to_cnt_d = to_cnt_q + 8'h01;
		end
		if (center_q && lb_good_evt && good_cnt_q != 8'hFF) begin
			good_cnt_d = good_cnt_q + 8'h01;
		end
		if (ctrl_clear) begin
			to_cnt_d   = 8'h00;
			good_cnt_d = 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			to_cnt_q   <= 8'h00;
			good_cnt_q <= 8'h00;
		end else begin
			to_cnt_q   <= to_cnt_d;
			good_cnt_q <= good_cnt_d;
		end
	end

	always_comb begin
		lb_ctrl_d = lb_ctrl_q;
		if (wr && sel(waddr, olr_pkg::OFF_LB_CTRL)) begin
			lb_ctrl_d = pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lb_ctrl_q <= olr_pkg::LB_CTRL_RESET;
		end else begin
			lb_ctrl_q <= lb_ctrl_d;
		end
	end

	always_comb begin
		model_d = model_q;
		if (wr && sel(waddr, olr_pkg::OFF_STATUS)) begin
			model_d = pwdata[5:4];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			model_q <= olr_pkg::MODEL_15KM;
		end else begin
			model_q <= model_d;
		end
	end

	// The capability bits are read-only and never take write data.
	always_comb begin
		rcmd_d = rcmd_q;
		if (wr && sel(waddr, olr_pkg::OFF_RCMD1)) begin
			rcmd_d = {pwdata[7:6], olr_pkg::EXT_CAPABILITY, pwdata[3:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcmd_q <= olr_pkg::RCMD1_RESET;
		end else begin
			rcmd_q <= rcmd_d;
		end
	end

	always_comb begin
		center_d = center_q;
		if (wr && sel(waddr, olr_pkg::OFF_CONFIG)) begin
			center_d = pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			center_q <= 1'b1;
		end else begin
			center_q <= center_d;
		end
	end

	always_comb begin
		link_d = port1_link_lost;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_q <= 1'b0;
		end else begin
			link_q <= link_d;
		end
	end

	assign flag_evt[olr_pkg::BIT_STOP]     = center_q && far_stop_evt;
	assign flag_evt[olr_pkg::BIT_OVERSTAY] = center_q && overstay_evt;
	assign flag_evt[olr_pkg::BIT_REPLY_TO] = center_q && reply_wait_evt;

	// Reading the status clears the flags; an event in the same cycle survives.
	always_comb begin
		flag_d = flag_q;
		for (int i = 1; i <= 3; i++) begin
			if (status_rd) begin
				flag_d[i] = 1'b0;
			end
			if (flag_evt[i]) begin
				flag_d[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 3'h0;
		end else begin
			flag_q <= flag_d;
		end
	end

	// Interrupt status is write-one-to-clear; a new event wins over the clear.
	always_comb begin
		ev = '0;
		ev[olr_pkg::IRQ_TO_COUNT]   = center_q && lb_timeout_evt;
		ev[olr_pkg::IRQ_GOOD_COUNT] = center_q && lb_good_evt;
		ev[olr_pkg::IRQ_STOP]       = flag_evt[olr_pkg::BIT_STOP];
		ev[olr_pkg::IRQ_OVERSTAY]   = flag_evt[olr_pkg::BIT_OVERSTAY];
		ev[olr_pkg::IRQ_REPLY_TO]   = flag_evt[olr_pkg::BIT_REPLY_TO];
		ev[olr_pkg::IRQ_LINK_LOST]  = port1_link_lost && !link_q;
		ist_d = ist_q;
		if (wr && sel(waddr, olr_pkg::OFF_IRQ_STATUS)) begin
			ist_d = ist_q & ~pwdata[olr_pkg::IRQ_W-1:0];
		end
		ist_d = ist_d | ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_q <= '0;
		end else begin
			ist_q <= ist_d;
		end
	end

	always_comb begin
		imask_d = imask_q;
		if (wr && sel(waddr, olr_pkg::OFF_IRQ_MASK)) begin
			imask_d = pwdata[olr_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imask_q <= '0;
		end else begin
			imask_q <= imask_d;
		end
	end

	always_comb begin
		pend_d = |(ist_d & imask_d);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
		end
	end

	// Decoded command outputs follow the register's next value.
	always_comb begin
		ext_d = (rcmd_d[1:0] == olr_pkg::MODE_EXTENDED);
		req_d = (cmd_pattern(rcmd_d) == olr_pkg::PAT_READ_REQ);
		ack_d = (cmd_pattern(rcmd_d) == olr_pkg::PAT_READ_ACK);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			center_side <= 1'b1;
			model_sel   <= olr_pkg::MODEL_15KM;
			ext_mode    <= 1'b0;
			read_req    <= 1'b0;
			read_ack    <= 1'b0;
			irq         <= 1'b0;
		end else begin
			center_side <= center_d;
			model_sel   <= model_d;
			ext_mode    <= ext_d;
			read_req    <= req_d;
			read_ack    <= ack_d;
			irq         <= pend_q;
		end
	end
endmodule : olr_regs

/* tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic        pready, pslverr, e, center_side, ext_mode, read_req, read_ack, irq;
	logic [1:0]  model_sel;
	logic [4:0]  ev = 5'h00;
	logic        port1_link_lost = 1'b0;
	wire logic   lb_timeout_evt, lb_good_evt, far_stop_evt, overstay_evt, reply_wait_evt;
	int          fail_count = 0;
	int          num_checks = 0;
	assign {reply_wait_evt, overstay_evt, far_stop_evt, lb_good_evt, lb_timeout_evt} = ev;
	always #25 pclk = ~pclk;
	olr_regs dut_u (.*);
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(negedge pclk); while (pready !== 1'b1 && ++t < 20);
		r = prdata;
		e = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		`CHK($sformatf("reg %h", a), {24'h0, x}, r)
	endtask : rd
	task automatic pulse(input int i, input int n);
		@(posedge pclk);
		ev[i] <= 1'b1;
		repeat (n) @(posedge pclk);
		ev[i] <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : pulse
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		final_report();
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h124, 8'h80);
		rd(12'h128, 8'h22);
		pulse(0, 3);
		pulse(1, 2);
		rd(12'h11C, 8'h03);
		rd(12'h120, 8'h02);
		apb(1'b1, 12'h110, 8'h00);
		rd(12'h11C, 8'h00);
		rd(12'h120, 8'h00);
		pulse(1, 260);
		rd(12'h120, 8'hFF);
		apb(1'b1, 12'h188, 8'h00);
		pulse(0, 2);
		rd(12'h11C, 8'h00);
		apb(1'b1, 12'h188, 8'h01);
		$display("counter test done");
		port1_link_lost <= 1'b1;
		pulse(2, 1);
		pulse(3, 1);
		pulse(4, 1);
		rd(12'h124, 8'h8F);
		port1_link_lost <= 1'b0;
		rd(12'h124, 8'h80);
		apb(1'b1, 12'h124, 8'hD0);
		rd(12'h124, 8'h90);
		$display("status test done");
		apb(1'b1, 12'h128, 8'h06);
		rd(12'h128, 8'h26);
		`CHK("decode", 3'b101, {read_req, read_ack, ext_mode})
		apb(1'b1, 12'h128, 8'h44);
		repeat (2) @(posedge pclk);
		`CHK("decode", 3'b010, {read_req, read_ack, ext_mode})
		$display("command test done");
		apb(1'b1, 12'h180, 8'h3F);
		apb(1'b1, 12'h184, 8'h01);
		pulse(1, 1);
		`CHK("irq", 1'b0, irq)
		pulse(0, 1);
		`CHK("irq", 1'b1, irq)
		apb(1'b1, 12'h180, 8'h01);
		repeat (3) @(posedge pclk);
		`CHK("irq", 1'b0, irq)
		rd(12'h200, 8'h00);
		`CHK("pslverr", 1'b1, e)
		$display("irq test done");
		final_report();
	end
endmodule : tb_top
